// ---- src/dacr_device.sv ----
/*
  Device end: conversion control, shutdown and dual serial readout.
  Assumes osc_clk is a free running internal oscillator; the convert-start and select pins are
  asynchronous to it and are synchronised before use. Serial data is shifted
  on the falling edge of the link's sclk.
*/
`timescale 1ns/10ps
module dacr_device #(
  parameter int WORD_BITS = dacr_pkg::WORD_BITS,
  parameter int CONV_CYCLES = dacr_pkg::CONV_CYCLES
) (
  input wire logic osc_clk,
  input wire logic rst,
  dacr_link_if.device link,
  input wire logic [WORD_BITS-1:0] sample_first,
  input wire logic [WORD_BITS-1:0] sample_second,
  output logic powered_down,
  output logic sampler_tracking
);
  typedef enum logic [1:0] {DACR_IDLE, DACR_CONV, DACR_SHUT} dacr_state_e;

  dacr_state_e state;
  logic [1:0] cnv_sync;
  logic [1:0] cs_sync;
  logic cnv_prev;
  logic cs_prev;
  logic [7:0] conv_cnt;
  logic [WORD_BITS-1:0] result_first;
  logic [WORD_BITS-1:0] result_second;
  logic result_toggle;
  logic taken_toggle;
  logic fresh;
  logic show_result;
  logic [2*WORD_BITS-1:0] shift_first;
  logic [2*WORD_BITS-1:0] shift_second;
  logic cs_seen_n;
  logic cnv_fall;
  logic cs_fall;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers on the oscillator domain
  always_ff @(posedge osc_clk or posedge rst) begin
    if (rst) begin
      cnv_sync <= 2'h3;
      cs_sync <= 2'h3;
      cnv_prev <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cnv_sync <= {cnv_sync[0], link.convert_start_n};
      cs_sync <= {cs_sync[0], link.chip_select_n};
      cnv_prev <= cnv_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  assign cnv_fall = cnv_prev & ~cnv_sync[1];
  assign cs_fall = cs_prev & ~cs_sync[1];

  //////////////////////////////////////////////////////////////////////////////
  // Conversion control on the internal oscillator
  always_ff @(posedge osc_clk or posedge rst) begin // see RULE6
    if (rst) begin
      state <= DACR_IDLE;
      conv_cnt <= 8'h00;
      link.busy <= 1'b0;
      powered_down <= 1'b0;
      result_first <= '0;
      result_second <= '0;
      result_toggle <= 1'b0;
    end else begin
      case (state)
        DACR_IDLE: begin
          if (cnv_fall) begin // see RULE2
            state <= DACR_CONV;
            link.busy <= 1'b1; // see RULE5
            conv_cnt <= 8'h00;
          end
        end
        DACR_CONV: begin
          if (conv_cnt == 8'(CONV_CYCLES - 1)) begin
            link.busy <= 1'b0; // see RULE5
            result_first <= sample_first;
            result_second <= sample_second;
            result_toggle <= ~result_toggle;
            if (!cnv_sync[1]) begin // see RULE1
              state <= DACR_SHUT; // see RULE4
              powered_down <= 1'b1;
            end else begin
              state <= DACR_IDLE;
            end
          end else begin
            conv_cnt <= conv_cnt + 8'h01;
          end
        end
        DACR_SHUT: begin
          if (cnv_sync[1]) begin // see RULE18
            state <= DACR_IDLE;
            powered_down <= 1'b0;
          end
        end
        default: state <= DACR_IDLE;
      endcase
    end
  end

  // Sampler tracks once busy is low after a select fall, except in shutdown; holds at start
  always_ff @(posedge osc_clk or posedge rst) begin // see RULE23
    if (rst) begin
      sampler_tracking <= 1'b0;
    end else if (cnv_fall) begin
      sampler_tracking <= 1'b0;
    end else if (!link.busy && (cs_fall || !cs_sync[1]) && state != DACR_SHUT) begin
      sampler_tracking <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial side on the link clock. A result stays fresh until an sclk fall takes it;
  // the host clocks only once busy is low, so the toggle has settled by then.
  assign fresh = result_toggle ^ taken_toggle; // see RULE21 see RULE22

  // Tracks whether the current select-low period has had its first fall
  always_ff @(negedge link.sclk or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      cs_seen_n <= 1'b1;
    end else begin
      cs_seen_n <= 1'b0; // see RULE12
    end
  end

  // First fall of a frame or of a new result moves on to the second bit
  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      shift_first <= '0;
      shift_second <= '0;
      taken_toggle <= 1'b0;
    end else if (cs_seen_n || fresh) begin
      shift_first <= {result_first[WORD_BITS-2:0], result_second, 1'b0}; // see RULE24
      shift_second <= {result_second[WORD_BITS-2:0], result_first, 1'b0}; // see RULE13
      taken_toggle <= result_toggle;
    end else begin
      shift_first <= {shift_first[2*WORD_BITS-2:0], 1'b0}; // see RULE9
      shift_second <= {shift_second[2*WORD_BITS-2:0], 1'b0};
    end
  end

  // MSB comes straight from the result until the first fall takes it
  assign show_result = cs_seen_n | fresh;
  assign link.serial_out_first = show_result ? result_first[WORD_BITS-1] // see RULE8 see RULE10
                                             : shift_first[2*WORD_BITS-1];
  assign link.serial_out_second = show_result ? result_second[WORD_BITS-1] // see RULE7
                                              : shift_second[2*WORD_BITS-1];
  assign link.serial_out_first_oe = ~link.chip_select_n; // see RULE15 see RULE14 see RULE22
  assign link.serial_out_second_oe = ~link.chip_select_n; // see RULE17
endmodule

// ---- src/dacr_pkg.sv ----
/*
  Constants shared by both ends of the dual converter control and serial readout link.
  Assumes a 200 MHz host clock and a device that converts on its own oscillator and shifts on the link's serial clock.
*/
// Functional notes
// RULE1 - Convert-start level at busy fall picks mode
// RULE2 - Convert-start fall starts both conversions together
// RULE3 - Host raises convert-start before busy falls
// RULE4 - Low convert-start at busy fall shuts down
// RULE5 - Busy high through conversion, falls at result
// RULE6 - Conversion timed by internal oscillator
// RULE7 - One serial output per converter
// RULE8 - Select fall drives outputs, shows MSB
// RULE9 - MSB first, later bits on clock fall
// RULE10 - First bit valid at first clock fall
// RULE11 - Host gives at least word-length clock pulses
// RULE12 - Clock fall coinciding with select fall ignored
// RULE13 - Further word-length clocks shift other result
// RULE14 - Outputs keep driving after dual read
// RULE15 - Select rise ends read, floats outputs
// RULE16 - Host waits quiet time before next start
// RULE17 - Shutdown still delivers last results
// RULE18 - Host holds convert-start high 70 us to wake
// RULE19 - Power-on needs 70 us high, no dummy
// RULE20 - Host keeps convert-start low to shut down
// RULE21 - Early select fall gives MSB at busy fall
// RULE22 - Select held low never floats outputs
// RULE23 - Sampler tracks after busy fall, holds at start; the code tracks only once select is low, and never in shutdown
// RULE24 - Each select fall restarts from MSB
package dacr_pkg;
  localparam int WORD_BITS = 14;
  localparam int CONV_CYCLES = 40;
  localparam int POWER_UP_TIME_US = 70;
  localparam int CLK_MHZ = 200;
  localparam int POWER_UP_CYCLES = POWER_UP_TIME_US * CLK_MHZ;
  localparam int QUIET_GAP_TIME_NS = 50;
  localparam int CLK_PERIOD_NS = 5;
  localparam int QUIET_GAP_CYCLES = (QUIET_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_BEFORE_BUSY_FALL_TIME_NS = 20;
  localparam int SCLK_DIV = 4;
endpackage

// ---- src/dacr_link_if.sv ----
/*
  Link between the converter device end and the host end.
  Assumes the bench passes the two data wires straight through and checks the output enables and the first data wire's shift timing.
*/
`timescale 1ns/10ps
interface dacr_link_if;
  logic convert_start_n;
  logic chip_select_n;
  logic sclk;
  logic busy;
  logic serial_out_first;
  logic serial_out_first_oe;
  logic serial_out_second;
  logic serial_out_second_oe;
  modport device (
    input convert_start_n,
    input chip_select_n,
    input sclk,
    output busy,
    output serial_out_first,
    output serial_out_first_oe,
    output serial_out_second,
    output serial_out_second_oe
  );
  modport host (
    output convert_start_n,
    output chip_select_n,
    output sclk,
    input busy,
    input serial_out_first,
    input serial_out_first_oe,
    input serial_out_second,
    input serial_out_second_oe
  );
endinterface

// ---- src/dacr_host.sv ----
/*
  Host end: drives convert-start, chip select and a divided serial clock,
  and collects both results.
  Assumes a 200 MHz clk; busy and data pins are synchronised before use.
*/
`timescale 1ns/10ps
module dacr_host #(
  parameter int WORD_BITS = dacr_pkg::WORD_BITS,
  parameter int POWER_UP_CYCLES = dacr_pkg::POWER_UP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  dacr_link_if.host link,
  input wire logic start,
  input wire logic shutdown_after,
  input wire logic dual_read,
  output logic ready,
  output logic done,
  output logic [WORD_BITS-1:0] result_first,
  output logic [WORD_BITS-1:0] result_second
);
  typedef enum logic [2:0] {DACH_WAKE, DACH_IDLE, DACH_CONV, DACH_READ, DACH_QUIET} dach_state_e;

  dach_state_e state;
  logic [$clog2(POWER_UP_CYCLES+1)-1:0] wait_cnt;
  logic [1:0] busy_sync;
  logic [1:0] da_sync;
  logic [1:0] db_sync;
  logic [$clog2(dacr_pkg::SCLK_DIV)-1:0] div_cnt;
  logic [5:0] bits;
  logic [5:0] bits_goal;
  logic shutdown_req;
  logic [2*WORD_BITS-1:0] cap_a;
  logic [WORD_BITS-1:0] cap_b;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_sync <= 2'h0;
      da_sync <= 2'h0;
      db_sync <= 2'h0;
    end else begin
      busy_sync <= {busy_sync[0], link.busy};
      da_sync <= {da_sync[0], link.serial_out_first};
      db_sync <= {db_sync[0], link.serial_out_second};
    end
  end

  assign ready = (state == DACH_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // Sequence control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= DACH_WAKE;
      wait_cnt <= '0;
      link.convert_start_n <= 1'b1;
      link.chip_select_n <= 1'b1;
      link.sclk <= 1'b1;
      div_cnt <= '0;
      bits <= 6'h00;
      bits_goal <= 6'h00;
      shutdown_req <= 1'b0;
      done <= 1'b0;
      cap_a <= '0;
      cap_b <= '0;
      result_first <= '0;
      result_second <= '0;
    end else begin
      done <= 1'b0;
      case (state)
        DACH_WAKE: begin
          link.convert_start_n <= 1'b1;
          if (wait_cnt == ($bits(wait_cnt))'(POWER_UP_CYCLES - 1)) begin // see RULE18 see RULE19
            state <= DACH_IDLE;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        DACH_IDLE: begin
          if (start) begin
            link.convert_start_n <= 1'b0;
            shutdown_req <= shutdown_after;
            bits_goal <= dual_read ? 6'(2 * WORD_BITS) : 6'(WORD_BITS);
            state <= DACH_CONV;
            wait_cnt <= '0;
          end
        end
        DACH_CONV: begin
          if (wait_cnt != '1) begin
            wait_cnt <= wait_cnt + 1'b1;
          end
          if (!shutdown_req && wait_cnt == ($bits(wait_cnt))'(4)) begin
            link.convert_start_n <= 1'b1; // see RULE3
          end
          if (wait_cnt > ($bits(wait_cnt))'(8) && !busy_sync[1]) begin
            link.chip_select_n <= 1'b0;
            div_cnt <= '0;
            bits <= 6'h00;
            state <= DACH_READ;
          end
        end
        DACH_READ: begin
          div_cnt <= div_cnt + 1'b1;
          if (div_cnt == '0) begin
            link.sclk <= 1'b0;
          end else if (div_cnt == ($bits(div_cnt))'(dacr_pkg::SCLK_DIV / 2)) begin
            link.sclk <= 1'b1;
            if (bits == bits_goal) begin
              link.chip_select_n <= 1'b1; // see RULE15
              result_first <= dual_read ? cap_a[2*WORD_BITS-1:WORD_BITS] : cap_a[WORD_BITS-1:0];
              result_second <= dual_read ? cap_a[WORD_BITS-1:0] : cap_b;
              done <= 1'b1;
              wait_cnt <= '0;
              state <= DACH_QUIET;
            end else begin
              cap_a <= {cap_a[2*WORD_BITS-2:0], da_sync[1]}; // see RULE11
              cap_b <= {cap_b[WORD_BITS-2:0], db_sync[1]};
              bits <= bits + 6'h01;
            end
          end
        end
        DACH_QUIET: begin
          wait_cnt <= wait_cnt + 1'b1;
          if (wait_cnt == ($bits(wait_cnt))'(dacr_pkg::QUIET_GAP_CYCLES)) begin // see RULE16
            wait_cnt <= '0;
            state <= shutdown_req ? DACH_WAKE : DACH_IDLE; // see RULE20
            link.convert_start_n <= 1'b1;
          end
        end
        default: state <= DACH_IDLE;
      endcase
    end
  end
endmodule

// ---- tb/dacr_link_checker.sv ----
/*
  Checker for the converter link: watches the shared interface signals.
  Assumes all link signals are sampled on the 200 MHz host clock.
*/
`timescale 1ns/10ps
module dacr_link_checker #(
  parameter int WORD_BITS = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic convert_start_n,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic busy,
  input wire logic serial_out_first,
  input wire logic serial_out_first_oe,
  input wire logic serial_out_second,
  input wire logic serial_out_second_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int fall_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Serial clock falls seen within the current frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fall_cnt <= 0;
    end else if (chip_select_n) begin
      fall_cnt <= 0;
    end else if ($fell(sclk)) begin
      fall_cnt <= fall_cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    $fell(convert_start_n);
  endsequence
  sequence s_conv;
    $rose(busy);
  endsequence
  property p_oe_first;
    serial_out_first_oe == !chip_select_n;
  endproperty
  property p_oe_second;
    serial_out_second_oe == !chip_select_n;
  endproperty
  property p_busy_rise;
    s_start |-> ##[1:20] busy;
  endproperty
  property p_busy_hold;
    s_conv |-> busy [*8] ##30 busy;
  endproperty
  property p_busy_fall;
    s_conv |-> ##[40:80] !busy;
  endproperty
  property p_shutdown;
    $fell(busy) && !convert_start_n |-> (!busy) [*8];
  endproperty
  property p_sclk_count;
    $rose(chip_select_n) |-> $past(fall_cnt) >= WORD_BITS;
  endproperty
  property p_shift_on_fall;
    !chip_select_n && $past(!chip_select_n) && !busy && $past(!busy)
      && $changed(serial_out_first) |-> $fell(sclk);
  endproperty
  a_oe_first: assert property (p_oe_first) else $error("first output enable wrong");
  a_oe_second: assert property (p_oe_second) else $error("second output enable wrong");
  a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  a_busy_fall: assert property (p_busy_fall) else $error("busy did not fall");
  a_shutdown: assert property (p_shutdown) else $error("converted in shutdown");
  a_sclk_count: assert property (p_sclk_count) else $error("too few clocks");
  a_shift_on_fall: assert property (p_shift_on_fall) else $error("data off clock fall");
endmodule

// ---- tb/dual_adc_convert_and_serial_readout_tb_top.sv ----
/*
  Bench joining host and device ends through the link interface.
  Assumes a 200 MHz host clock and a 6 ns free running device oscillator.
*/
`timescale 1ns/10ps
module dual_adc_convert_and_serial_readout_tb_top;
  localparam int W = dacr_pkg::WORD_BITS;
  logic clk = 1'b0;
  logic osc_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic shutdown_after = 1'b0;
  logic dual_read = 1'b0;
  logic [W-1:0] sample_first = '0;
  logic [W-1:0] sample_second = '0;
  logic powered_down;
  logic sampler_tracking;
  logic ready;
  logic done;
  logic [W-1:0] result_first;
  logic [W-1:0] result_second;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  dacr_link_if link ();
  dacr_device #(.WORD_BITS(W), .CONV_CYCLES(dacr_pkg::CONV_CYCLES)) dacr_device_inst (
    .osc_clk(osc_clk), .rst(rst), .link(link), .sample_first(sample_first),
    .sample_second(sample_second), .powered_down(powered_down),
    .sampler_tracking(sampler_tracking));
  dacr_host #(.WORD_BITS(W), .POWER_UP_CYCLES(20)) dacr_host_inst (
    .clk(clk), .rst(rst), .link(link), .start(start), .shutdown_after(shutdown_after),
    .dual_read(dual_read), .ready(ready), .done(done), .result_first(result_first),
    .result_second(result_second));
  dacr_link_checker #(.WORD_BITS(W)) dacr_link_checker_inst (
    .clk(clk), .rst(rst), .convert_start_n(link.convert_start_n),
    .chip_select_n(link.chip_select_n), .sclk(link.sclk), .busy(link.busy),
    .serial_out_first(link.serial_out_first), .serial_out_first_oe(link.serial_out_first_oe),
    .serial_out_second(link.serial_out_second),
    .serial_out_second_oe(link.serial_out_second_oe));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #1.3;
    forever #3 osc_clk = ~osc_clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One conversion and read, results checked against the applied levels
  task automatic convert(input logic [W-1:0] a, input logic [W-1:0] b, input logic dual,
                         input logic sd);
    int n;
    @(negedge clk);
    sample_first = a;
    sample_second = b;
    dual_read = dual;
    shutdown_after = sd;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check(result_first, a);
    check(result_second, b);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_single();
    convert(14'h2A55, 14'h15AA, 1'b0, 1'b0);
    check(W'(powered_down), W'(1'b0));
    check(W'(sampler_tracking), W'(1'b1));
  endtask
  task automatic t_dual();
    convert(14'h3C01, 14'h0003, 1'b1, 1'b0);
    check(W'(powered_down), W'(1'b0));
  endtask
  task automatic t_shutdown();
    convert(14'h0001, 14'h2000, 1'b0, 1'b1);
    check(W'(powered_down), W'(1'b1));
    check(W'(sampler_tracking), W'(1'b0));
  endtask
  task automatic t_wake();
    convert(14'h1234, 14'h0ABC, 1'b1, 1'b0);
    check(W'(powered_down), W'(1'b0));
  endtask
  task automatic t_back_to_back();
    convert(14'h3FFF, 14'h0000, 1'b0, 1'b0);
    convert(14'h0000, 14'h3FFF, 1'b0, 1'b0);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_single();
    t_dual();
    t_shutdown();
    t_wake();
    t_back_to_back();
    wrap_up();
  end
endmodule
